// File: uart_rx_timeout_break_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uart_rx_timeout_break_logic_tb;
  logic                        core_clk;
  logic                        resetn;
  logic                        bit_tick;
  logic                        sample_tick;
  logic                        over8_mode;
  logic                        sync_mode;
  logic [utb_pkg::DELAY_W-1:0] idle_delay_value;
  logic [utb_pkg::GUARD_W-1:0] guard_period_count;
  logic [4:0]                  cmd;
  logic                        thr_write;
  logic [7:0]                  tx_holding_data;
  logic                        rx_ready;
  logic                        rxd_line;
  logic                        txd;
  logic                        free;
  logic                        tx_idle;
  logic                        expired;
  logic                        frame;
  logic                        brk;
  logic                        ovr;
  logic                        rx_valid;
  logic [7:0]                  rx_data;
  logic [5:0]                  bit_cyc;
  logic [5:0]                  div;
  logic [8:0]                  f;
  logic                        b;
  int                          n;
  int                          errors;
  int                          checked;

  assign bit_cyc = over8_mode ? 6'h10 : 6'h20;

  utb_core i_utb_core
  (
    .core_clk              (core_clk),
    .resetn                (resetn),
    .bit_tick              (bit_tick),
    .sample_tick           (sample_tick),
    .sync_mode             (sync_mode),
    .over8_mode            (over8_mode),
    .rxd_pin               (rxd_line),
    .idle_delay_value      (idle_delay_value),
    .guard_period_count    (guard_period_count),
    .arm_idle_wait_cmd     (cmd[0]),
    .reload_idle_count_cmd (cmd[1]),
    .clear_status_cmd      (cmd[2]),
    .begin_break_cmd       (cmd[3]),
    .end_break_cmd         (cmd[4]),
    .thr_write             (thr_write),
    .tx_holding_data       (tx_holding_data),
    .rx_ready              (rx_ready),
    .txd                   (txd),
    .tx_holding_free_flag  (free),
    .tx_idle_flag          (tx_idle),
    .idle_expired_flag     (expired),
    .frame_error_flag      (frame),
    .rx_break_flag         (brk),
    .overrun_flag          (ovr),
    .rx_valid              (rx_valid),
    .rx_data               (rx_data)
  );

  utb_remote i_utb_remote
  (
    .core_clk (core_clk),
    .bit_cyc  (bit_cyc),
    .rxd_line (rxd_line)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // one sample every other cycle, so a bit is 16 or 8 samples by mode
  always @(negedge core_clk)
  begin
    div         <= (div >= bit_cyc - 6'h01) ? 6'h00 : div + 6'h01;
    sample_tick <= div[0];
    bit_tick    <= (div == bit_cyc - 6'h01);
  end

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic pulse(input logic [4:0] m);
    cmd = m;
    @(negedge core_clk);
    cmd = 5'h00;
  endtask

  task automatic write_thr(input logic [7:0] d);
    tx_holding_data = d;
    thr_write       = 1'b1;
    @(negedge core_clk);
    thr_write       = 1'b0;
  endtask

  // txd is read one cycle after the bit edge has landed
  task automatic next_bit(output logic v);
    int k;
    k = 0;
    while (bit_tick !== 1'b1 && k < 100)
    begin
      @(negedge core_clk);
      k++;
    end
    @(negedge core_clk);
    v = txd;
  endtask

  task automatic wait_bits(input int k);
    logic v;
    repeat (k) next_bit(v);
    repeat (2) @(negedge core_clk);
  endtask

  // consumes the first bit that differs from lvl
  task automatic count_run(input logic lvl, output int k);
    logic v;
    k = 0;
    next_bit(v);
    while (v === lvl && k < 40)
    begin
      k++;
      next_bit(v);
    end
  endtask

  task automatic get_rx(input logic [7:0] exp);
    int k;
    k = 0;
    while (rx_valid !== 1'b1 && k < 400)
    begin
      @(negedge core_clk);
      k++;
    end
    chk(rx_data === exp, "receive data");
    rx_ready = 1'b1;
    @(negedge core_clk);
    rx_ready = 1'b0;
    // an edge passes, so a next call never re-raises ready in the same step
    @(negedge core_clk);
  endtask

  initial
  begin
    repeat (80000) @(posedge core_clk);
    errors++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    complete_run();
  end

  initial
  begin
    resetn = 1'b0;
    div = 6'h00;
    bit_tick = 1'b0;
    sample_tick = 1'b0;
    over8_mode = 1'b0;
    sync_mode = 1'b0;
    idle_delay_value = 16'h0003;
    guard_period_count = 8'h00;
    cmd = 5'h00;
    thr_write = 1'b0;
    tx_holding_data = 8'h00;
    rx_ready = 1'b0;
    repeat (9) @(negedge core_clk);
    resetn = 1'b1;
    @(negedge core_clk);
    chk({txd, free, tx_idle, expired, frame, brk, ovr, rx_valid} === 8'hE0, "reset state");
    // idle timer
    pulse(5'h01);
    wait_bits(6);
    chk(expired === 1'b0, "expiry while frozen");
    i_utb_remote.send(8'h3c, 1'b1, 1'b0);
    get_rx(8'h3c);
    wait_bits(1);
    chk(expired === 1'b0, "expiry too early after char");
    wait_bits(2);
    chk(expired === 1'b1, "no expiry after char");
    idle_delay_value = 16'h0004;
    pulse(5'h02);
    wait_bits(3);
    chk(expired === 1'b0, "expiry too early after reload");
    wait_bits(2);
    chk(expired === 1'b1, "no expiry after reload");
    idle_delay_value = 16'h0000;
    repeat (2) @(negedge core_clk);
    pulse(5'h02);
    wait_bits(6);
    chk(expired === 1'b0, "expiry with zero delay");
    // framing error and receive break
    i_utb_remote.send(8'h55, 1'b0, 1'b0);
    wait_bits(2);
    chk(frame === 1'b1 && brk === 1'b0, "framing flag");
    pulse(5'h04);
    chk(frame === 1'b0, "framing flag not cleared");
    get_rx(8'h55);
    i_utb_remote.send(8'h00, 1'b0, 1'b1);
    chk(brk === 1'b1 && frame === 1'b0, "break flag");
    pulse(5'h04);
    chk(brk === 1'b0, "break flag not cleared");
    i_utb_remote.release_line();
    wait_bits(1);
    chk(brk === 1'b1 && rx_valid === 1'b0, "break end");
    pulse(5'h04);
    over8_mode = 1'b1;
    wait_bits(1);
    i_utb_remote.send(8'hc3, 1'b1, 1'b0);
    get_rx(8'hc3);
    over8_mode = 1'b0;
    // synchronous receive: one sample on each bit clock
    sync_mode = 1'b1;
    wait_bits(1);
    i_utb_remote.send(8'ha5, 1'b1, 1'b0);
    get_rx(8'ha5);
    i_utb_remote.send(8'h00, 1'b0, 1'b1);
    chk(brk === 1'b1 && frame === 1'b0, "sync break flag");
    pulse(5'h04);
    i_utb_remote.release_line();
    wait_bits(2);
    chk(brk === 1'b1 && rx_valid === 1'b0, "sync break end");
    pulse(5'h04);
    sync_mode = 1'b0;
    wait_bits(1);
    // fifo filled past depth with the sink stalled, then drained
    for (int i = 0; i < 17; i++)
      i_utb_remote.send(8'h10 + 8'(i), 1'b1, 1'b0);
    chk(ovr === 1'b1, "overrun flag");
    for (int i = 0; i < 16; i++)
      get_rx(8'h10 + 8'(i));
    chk(rx_valid === 1'b0, "fifo not empty");
    pulse(5'h04);
    // break with early removal and a longer guard
    guard_period_count = 8'h0e;
    pulse(5'h08);
    chk(free === 1'b0, "free after break accept");
    write_thr(8'hff);
    chk(tx_idle === 1'b0, "idle after break accept");
    count_run(1'b1, n);
    pulse(5'h10);
    @(negedge core_clk);
    pulse(5'h08);
    count_run(1'b0, n);
    chk(n == 9, "break low length");
    write_thr(8'h00);
    count_run(1'b1, n);
    chk(n >= 13 && n <= 15, "recovery high length");
    for (int i = 0; i < 9; i++)
      next_bit(f[i]);
    chk(f === 9'h100, "char after break");
    // stray removal, then a break requested mid character
    guard_period_count = 8'h00;
    wait_bits(2);
    pulse(5'h10);
    write_thr(8'h5a);
    repeat (2) @(negedge core_clk);
    pulse(5'h08);
    count_run(1'b1, n);
    for (int i = 0; i < 9; i++)
      next_bit(f[i]);
    chk(f === 9'h15a, "char before break");
    n = 0;
    repeat (15)
    begin
      next_bit(b);
      if (b === 1'b0)
        n++;
    end
    chk(n == 15, "break held until removal");
    pulse(5'h10);
    count_run(1'b0, n);
    chk(n <= 1, "break not removed");
    wait_bits(14);
    chk(txd === 1'b1, "line after recovery");
    complete_run();
  end
endmodule
`default_nettype wire

// File: utb_core.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - zero idle delay disables time-out; expiry flag stays low.
// - nonzero delay loads a sixteen-bit down-counter.
// - counter decrements each bit period, reloads on every received character.
// - counter reaching zero raises the idle-expired flag.
// - arm command freezes counting until the first character arrives.
// - reload command reloads and starts counting at once.
// - stop bit sampled low flags a framing error, unless all data bits are zero.
// - framing flag sets at mid stop bit, clears only on clear-status.
// - break holds the line low one full character, until removal.
// - begin-break during a character waits for that character to finish.
// - further begin-break commands are ignored until the break completes.
// - early end-break still gets the full minimum break.
// - break commands need holding-free; break start clears holding-free and idle.
// - end-break without an accepted begin-break is ignored.
// - holding-register write while break is pending is dropped.
// - after break, line high twelve bits or guard period if larger.
// - all-zero character with low stop sets break flag, not framing flag.
// - clear-status clears the receive break flag.
// - break end on short high level also sets break flag.
// - async sampling at sixteen or eight per bit, by mode bit.
module utb_core
(
  input  wire logic                          core_clk,
  input  wire logic                          resetn,
  input  wire logic                          bit_tick,
  input  wire logic                          sample_tick,
  input  wire logic                          sync_mode,
  input  wire logic                          over8_mode,
  input  wire logic                          rxd_pin,
  input  wire logic [utb_pkg::DELAY_W-1:0]   idle_delay_value,
  input  wire logic [utb_pkg::GUARD_W-1:0]   guard_period_count,
  input  wire logic                          arm_idle_wait_cmd,
  input  wire logic                          reload_idle_count_cmd,
  input  wire logic                          clear_status_cmd,
  input  wire logic                          begin_break_cmd,
  input  wire logic                          end_break_cmd,
  input  wire logic                          thr_write,
  input  wire logic [utb_pkg::DATA_W-1:0]    tx_holding_data,
  input  wire logic                          rx_ready,
  output logic                               txd,
  output logic                               tx_holding_free_flag,
  output logic                               tx_idle_flag,
  output logic                               idle_expired_flag,
  output logic                               frame_error_flag,
  output logic                               rx_break_flag,
  output logic                               overrun_flag,
  output logic                               rx_valid,
  output logic [utb_pkg::DATA_W-1:0]         rx_data
);
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // ---- receive pin, two flops before any use
  logic rx_meta;
  logic rx_sync;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end
    else
    begin
      rx_meta <= rxd_pin;
      rx_sync <= rx_meta;
    end
  end

  // ---- receiver sample timing
  logic                        rx_busy;
  logic                        rx_in_brk;
  logic [3:0]                  rx_phase;
  logic [3:0]                  rx_bitn;
  logic [utb_pkg::DATA_W-1:0]  rx_shift;
  logic [1:0]                  rx_hi;
  logic                        rx_push;
  logic                        rx_got;
  logic [utb_pkg::DATA_W-1:0]  rx_word;

  // declared ahead of the wires that read the buffer's ready
  utb_stream_if #(.W(utb_pkg::DATA_W)) rx_in_if ();
  utb_stream_if #(.W(utb_pkg::DATA_W)) rx_out_if ();

  // sync mode samples once per bit clock, so half and full collapse to zero
  wire logic       smp  = sync_mode ? bit_tick : sample_tick;
  wire logic [3:0] ovs_half = over8_mode ? utb_pkg::OVS8_HALF : utb_pkg::OVS16_HALF;
  wire logic [3:0] ovs_full = over8_mode ? utb_pkg::OVS8_FULL : utb_pkg::OVS16_FULL;
  wire logic [3:0] half = sync_mode ? 4'h0 : ovs_half;
  wire logic [3:0] full = sync_mode ? 4'h0 : ovs_full;
  wire logic [1:0] ovs_end  = over8_mode ? utb_pkg::END_HI_8 : utb_pkg::END_HI_16;
  wire logic [1:0] end_need = sync_mode ? utb_pkg::END_HI_SYNC : ovs_end;

  wire logic hunting   = !rx_busy && !rx_in_brk;
  wire logic start_hit = smp && hunting && !rx_sync && rx_phase == half;
  wire logic at_point  = smp && rx_busy && rx_phase == full;
  wire logic stop_eval = at_point && rx_bitn == utb_pkg::DATA_BITS;
  wire logic brk_seen  = stop_eval && !rx_sync && rx_shift == '0;
  wire logic frame_bad = stop_eval && !rx_sync && rx_shift != '0;
  wire logic char_ok   = stop_eval && !brk_seen;
  wire logic brk_end   = smp && rx_in_brk && rx_sync && rx_hi + 2'h1 == end_need;
  wire logic rx_space  = rx_in_if.ready;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      rx_busy  <= 1'b0;
      rx_phase <= 4'h0;
      rx_bitn  <= 4'h0;
      rx_shift <= '0;
    end
    else if (start_hit)
    begin
      rx_busy  <= 1'b1;
      rx_phase <= 4'h0;
      rx_bitn  <= 4'h0;
    end
    else if (at_point)
    begin
      // hunting restarts right after the stop sample, unless that sample saw a break
      rx_phase <= 4'h0;
      rx_busy  <= !stop_eval;
      rx_bitn  <= rx_bitn + 4'h1;
      if (!stop_eval)
        rx_shift <= {rx_sync, rx_shift[utb_pkg::DATA_W-1:1]};
    end
    else if (smp && rx_busy)
      rx_phase <= rx_phase + 4'h1;
    else if (smp && hunting)
      rx_phase <= rx_sync ? 4'h0 : rx_phase + 4'h1;
    else if (rx_in_brk)
      rx_phase <= 4'h0;
  end

  // ---- break end tracking, a low sample restarts the high count
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      rx_in_brk <= 1'b0;
      rx_hi     <= 2'h0;
    end
    else if (brk_seen)
    begin
      rx_in_brk <= 1'b1;
      rx_hi     <= 2'h0;
    end
    else if (brk_end)
      rx_in_brk <= 1'b0;
    else if (smp && rx_in_brk)
      rx_hi <= rx_sync ? rx_hi + 2'h1 : 2'h0;
  end

  // ---- status flags: a set in the clear cycle wins
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      frame_error_flag <= 1'b0;
      rx_break_flag    <= 1'b0;
      overrun_flag     <= 1'b0;
      rx_push          <= 1'b0;
      rx_got           <= 1'b0;
      rx_word          <= '0;
    end
    else
    begin
      frame_error_flag <= frame_bad || (frame_error_flag && !clear_status_cmd);
      rx_break_flag <= brk_seen || brk_end || (rx_break_flag && !clear_status_cmd);
      // a full fifo drops the character rather than stalling the line
      overrun_flag <= (char_ok && !rx_space) || (overrun_flag && !clear_status_cmd);
      rx_push <= char_ok && rx_space;
      rx_got  <= char_ok;
      if (char_ok)
        rx_word <= rx_shift;
    end
  end

  // ---- receive buffer
  assign rx_in_if.valid  = rx_push;
  assign rx_in_if.data   = rx_word;
  assign rx_out_if.ready = rx_ready;
  assign rx_valid        = rx_out_if.valid;
  assign rx_data         = rx_out_if.data;

  utb_fifo #(.W(utb_pkg::DATA_W), .DEPTH(utb_pkg::FIFO_DEPTH)) u_rx_fifo
  (
    .core_clk (core_clk),
    .resetn   (resetn),
    .wr       (rx_in_if),
    .rd       (rx_out_if)
  );

  // idle time-out, decremented by the receive bit clock
  utb_idle_timer #(.W(utb_pkg::DELAY_W)) u_idle
  (
    .core_clk              (core_clk),
    .resetn                (resetn),
    .bit_tick              (bit_tick),
    .char_rx               (rx_got),
    .arm_idle_wait_cmd     (arm_idle_wait_cmd),
    .reload_idle_count_cmd (reload_idle_count_cmd),
    .idle_delay_value      (idle_delay_value),
    .idle_expired_flag     (idle_expired_flag)
  );

  // ---- transmitter and break sequencing
  utb_pkg::utb_brk_e           brk_state;
  utb_pkg::utb_brk_e           next_brk;
  logic [utb_pkg::DATA_W-1:0]  tx_hold;
  logic [9:0]                  tx_shift;
  logic [3:0]                  tx_left;
  logic [7:0]                  brk_cnt;
  logic                        end_req;

  wire logic brk_idle = brk_state == utb_pkg::BRK_IDLE;
  wire logic brk_pend = brk_state == utb_pkg::BRK_PEND;
  wire logic brk_low  = brk_state == utb_pkg::BRK_MIN || brk_state == utb_pkg::BRK_HOLD;
  wire logic begin_ok = begin_break_cmd && tx_holding_free_flag && brk_idle;
  wire logic end_ok   = end_break_cmd && tx_holding_free_flag && brk_low && !end_req;
  wire logic thr_ok   = thr_write && tx_holding_free_flag && !brk_pend && !begin_ok;
  wire logic load     = !tx_holding_free_flag && brk_idle && tx_left == 4'h0;
  wire logic brk_go   = brk_pend && bit_tick && tx_left == 4'h0;
  wire logic cnt_done = bit_tick && brk_cnt == 8'h00;
  wire logic [7:0] rec_len = guard_period_count > utb_pkg::BRK_RECOVER_BITS ?
                             guard_period_count : utb_pkg::BRK_RECOVER_BITS;
  wire logic next_low = next_brk == utb_pkg::BRK_MIN || next_brk == utb_pkg::BRK_HOLD;
  wire logic txd_next = next_low ? 1'b0 : (tx_left != 4'h0 ? tx_shift[0] : 1'b1);
  wire logic to_rec = next_brk == utb_pkg::BRK_RECOVER && brk_state != utb_pkg::BRK_RECOVER;

  always_comb
  begin
    next_brk = brk_state;
    unique case (brk_state)
      utb_pkg::BRK_IDLE:
        if (begin_ok)
          next_brk = utb_pkg::BRK_PEND;
      utb_pkg::BRK_PEND:
        if (brk_go)
          next_brk = utb_pkg::BRK_MIN;
      utb_pkg::BRK_MIN:
        // the minimum character runs out before any end request counts
        if (cnt_done)
          next_brk = end_req ? utb_pkg::BRK_RECOVER : utb_pkg::BRK_HOLD;
      utb_pkg::BRK_HOLD:
        if (bit_tick && end_req)
          next_brk = utb_pkg::BRK_RECOVER;
      utb_pkg::BRK_RECOVER:
        if (cnt_done)
          next_brk = utb_pkg::BRK_IDLE;
      default:
        next_brk = utb_pkg::BRK_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      brk_state <= utb_pkg::BRK_IDLE;
      end_req   <= 1'b0;
      brk_cnt   <= 8'h00;
    end
    else
    begin
      brk_state <= next_brk;
      if (end_ok)
        end_req <= 1'b1;
      else if (brk_idle)
        end_req <= 1'b0;
      if (brk_go)
        brk_cnt <= {4'h0, utb_pkg::CHAR_BITS - 4'h1};
      else if (to_rec)
        brk_cnt <= rec_len - 8'h01;
      else if (bit_tick && brk_cnt != 8'h00)
        brk_cnt <= brk_cnt - 8'h01;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      txd      <= 1'b1;
      tx_hold  <= '0;
      tx_shift <= 10'h3ff;
      tx_left  <= 4'h0;
      tx_holding_free_flag <= 1'b1;
      tx_idle_flag         <= 1'b1;
    end
    else
    begin
      if (bit_tick)
        txd <= txd_next;
      if (thr_ok)
        tx_hold <= tx_holding_data;
      // a break is treated as a character entering and leaving the holding stage
      if (begin_ok || thr_ok)
        tx_holding_free_flag <= 1'b0;
      else if (brk_go || load)
        tx_holding_free_flag <= 1'b1;
      tx_idle_flag <= !begin_ok && !thr_ok && tx_holding_free_flag &&
                      tx_left == 4'h0 && brk_idle;
      if (load)
      begin
        tx_shift <= {1'b1, tx_hold, 1'b0};
        tx_left  <= utb_pkg::CHAR_BITS;
      end
      else if (bit_tick && tx_left != 4'h0)
      begin
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_left  <= tx_left - 4'h1;
      end
    end
  end

  // ---- checks
  frame_set_a : assert property (frame_bad |=> frame_error_flag)
    else $error("framing error not flagged");

  frame_hold_a : assert property (
    frame_error_flag && !clear_status_cmd |=> frame_error_flag)
    else $error("framing flag dropped without clear");

  break_rx_a : assert property (
    brk_seen && !frame_error_flag |=> rx_break_flag && !frame_error_flag)
    else $error("break flagged wrongly");

  break_low_a : assert property (brk_low |-> !txd)
    else $error("line high during break");

  // a begin while already pending simply stays pending
  begin_ignored_a : assert property (
    begin_break_cmd && !brk_idle |=> !brk_pend || $past(brk_pend))
    else $error("begin-break accepted during break");

  min_break_a : assert property (
    brk_state == utb_pkg::BRK_MIN && bit_tick && brk_cnt != 8'h00
    |=> brk_state == utb_pkg::BRK_MIN)
    else $error("break shorter than one character");

  pend_drop_a : assert property (brk_pend && thr_write |=> $stable(tx_hold))
    else $error("byte taken while break pending");

  break_start_a : assert property (begin_ok |=> !tx_holding_free_flag ##1 !tx_idle_flag)
    else $error("break start left flags set");

  recover_high_a : assert property (brk_state == utb_pkg::BRK_RECOVER |-> txd)
    else $error("line low during recovery");

  stray_end_a : assert property (end_break_cmd && brk_idle |=> !end_req)
    else $error("end-break taken without a break");

  break_end_a : assert property (brk_end |=> rx_break_flag && !rx_in_brk)
    else $error("break end not flagged");

endmodule
`default_nettype wire

// File: utb_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module utb_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
)
(
  input wire logic   core_clk,
  input wire logic   resetn,
  utb_stream_if.snk  wr,
  utb_stream_if.src  rd
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH)
    begin : g_bad_depth
      $error("fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp;
  logic [AW:0]  rp;

  wire logic full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  wire logic push = wr.valid && !full;
  wire logic pop  = rd.valid && rd.ready;

  assign wr.ready = !full;
  assign rd.valid = wp != rp;
  assign rd.data  = mem[rp[AW-1:0]];

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      wp <= '0;
      rp <= '0;
    end
    else
    begin
      if (push)
        wp <= wp + 1'b1;
      if (pop)
        rp <= rp + 1'b1;
    end
  end

  // storage carries no reset, only the pointers matter
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wp[AW-1:0]] <= wr.data;
  end

endmodule
`default_nettype wire

// File: utb_idle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module utb_idle_timer #(parameter int W = utb_pkg::DELAY_W)
(
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic         bit_tick,
  input  wire logic         char_rx,
  input  wire logic         arm_idle_wait_cmd,
  input  wire logic         reload_idle_count_cmd,
  input  wire logic [W-1:0] idle_delay_value,
  output logic              idle_expired_flag
);
  generate
    if (W < 2)
    begin : g_bad_w
      $error("delay width too small");
    end
  endgenerate

  logic [W-1:0] count;
  logic         run;

  wire logic off = idle_delay_value == '0;
  wire logic hit = bit_tick && run && count == W'(1);

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      count <= '0;
      run   <= 1'b0;
      idle_expired_flag <= 1'b0;
    end
    else
    begin
      // a zero delay turns the whole feature off
      idle_expired_flag <= !off && (hit ||
        (idle_expired_flag && !arm_idle_wait_cmd && !reload_idle_count_cmd));
      if (off)
        run <= 1'b0;
      else if (reload_idle_count_cmd)
      begin
        count <= idle_delay_value;
        run   <= 1'b1;
      end
      else if (arm_idle_wait_cmd)
      begin
        count <= idle_delay_value; // frozen until a character arrives
        run   <= 1'b0;
      end
      else if (char_rx)
      begin
        count <= idle_delay_value;
        run   <= 1'b1;
      end
      else if (bit_tick && run)
      begin
        count <= count - 1'b1;
        run   <= !hit;
      end
    end
  end

  idle_off_a : assert property (@(posedge core_clk) disable iff (!resetn)
    off |=> !idle_expired_flag)
    else $error("expiry flag set while delay is zero");

  reload_go_a : assert property (@(posedge core_clk) disable iff (!resetn)
    reload_idle_count_cmd && !off |=> run && count == $past(idle_delay_value))
    else $error("reload did not start the count");

endmodule
`default_nettype wire

// File: utb_pkg.sv
package utb_pkg;

  localparam int DATA_W     = 8;
  localparam int DELAY_W    = 16;
  localparam int GUARD_W    = 8;
  localparam int FIFO_DEPTH = 16;

  // start + 8 data + stop, no parity in this block
  localparam logic [3:0] CHAR_BITS = 4'ha;
  localparam logic [3:0] DATA_BITS = 4'h8;

  localparam logic [7:0] BRK_RECOVER_BITS = 8'h0c;

  localparam logic [3:0] OVS16_HALF = 4'h7;
  localparam logic [3:0] OVS16_FULL = 4'hf;
  localparam logic [3:0] OVS8_HALF  = 4'h3;
  localparam logic [3:0] OVS8_FULL  = 4'h7;

  // high samples that end a received break
  localparam logic [1:0] END_HI_16   = 2'h2;
  localparam logic [1:0] END_HI_8    = 2'h1;
  localparam logic [1:0] END_HI_SYNC = 2'h1;

  typedef enum logic [2:0]
  {
    BRK_IDLE    = 3'h0,
    BRK_PEND    = 3'h1,
    BRK_MIN     = 3'h3,
    BRK_HOLD    = 3'h2,
    BRK_RECOVER = 3'h6
  } utb_brk_e;

endpackage

// File: utb_remote.sv
`timescale 1ns/1ps
`default_nettype none
module utb_remote
(
  input  wire logic       core_clk,
  input  wire logic [5:0] bit_cyc,
  output var  logic       rxd_line
);
  // an idle async line rests high
  initial rxd_line = 1'b1;

  task automatic hold_bit(input logic lvl, input int cyc);
    rxd_line = lvl;
    repeat (cyc) @(negedge core_clk);
  endtask

  // low stop is held only past mid bit, so no false start follows it;
  // keep leaves the line low, as a break in progress
  task automatic send(input logic [7:0] d, input logic stop, input logic keep);
    hold_bit(1'b0, int'(bit_cyc));
    for (int i = 0; i < 8; i++)
      hold_bit(d[i], int'(bit_cyc));
    if (stop)
      hold_bit(1'b1, int'(bit_cyc));
    else
    begin
      hold_bit(1'b0, int'(bit_cyc) * 5 / 8);
      hold_bit(!keep, int'(bit_cyc) * 3 / 8);
    end
  endtask

  task automatic release_line();
    rxd_line = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: utb_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface utb_stream_if #(parameter int W = 8) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire
